// ===== logic/hmr_hub_ctrl.v
// hub mode control, reference clock select capture and interrupt pin
// assumes clk_sys is derived from the reference clock rising edge
`timescale 1ns/10ps
`include "hmr_defs.vh"

// Overview of operation
// RULE_01 - logic runs only on rising clock edges, duty cycle irrelevant
// RULE_02 - interrupt pin high at init: select 00..11 give 38.4/26/19.2/12 MHz
// RULE_03 - interrupt pin low at init: select 00..11 give 24/27/25/50 MHz
// RULE_04 - host holds pin low through init, then releases it to listen
// RULE_05 - status bits stay set until the host clears them
// RULE_06 - a bit sets only when its condition newly rises
// RULE_07 - interrupt conditions are recorded in the status register
// RULE_08 - a mask register chooses which status bits drive the pin
// RULE_09 - interrupt pin is open drain, pulled low when active
// RULE_10 - suspend option makes the pin show the hub suspend level
// RULE_11 - reset input low means standby, only watching the reset input
// RULE_12 - reset input high means full hub mode
// RULE_13 - in standby the pll is stopped and the core unpowered
// RULE_14 - configuration is lost in standby; host reconfigures afterwards
// RULE_15 - select pins and pin level are captured once during init
// RULE_16 - reset returns status and mask to defaults
// RULE_17 - pin active whenever any enabled status bit is set; here only while suspend_level_indicate is low
module hmr_hub_ctrl #(
    parameter INIT_CYCLES = `HMR_INIT_CYCLES,
    parameter NUM_COND = 8
) (
    input wire clk_sys,
    input wire reset,
    input wire reset_n_pin,
    input wire [1:0] ref_sel_pin,
    input wire irq_pin_in,
    output wire irq_pin_out,
    output wire irq_pin_oe_n,
    input wire [NUM_COND-1:0] hub_cond,
    input wire hub_suspended,
    input wire suspend_level_indicate,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata,
    output wire hub_mode,
    output wire init_busy,
    output wire pll_enable,
    output wire core_power_en,
    output wire [2:0] ref_freq_code
);
    localparam ST_STANDBY = 2'd0;
    localparam ST_INIT = 2'd1;
    localparam ST_RUN = 2'd2;

    reg [1:0] state_q;
    reg [1:0] state_d;
    reg [31:0] init_cnt_q;
    reg rst_pin_s1_q;
    reg rst_pin_s2_q;
    reg [1:0] sel_s1_q;
    reg [1:0] sel_s2_q;
    reg irq_s1_q;
    reg irq_s2_q;
    reg [2:0] freq_q;
    reg [7:0] mask_q;
    reg irq_active_q;
    reg [7:0] rdata_d;
    wire [7:0] status;
    wire [7:0] clear_bits;
    wire in_hub;
    wire cond_live;
    wire [NUM_COND+7:0] cond_wide;
    wire [7:0] cond_bus;

    // decode one serial port register address
    function hit;
        input [7:0] addr;
        input [7:0] ofs;
        begin
            hit = (addr == ofs);
        end
    endfunction

    // pins from outside pass two flip-flops before use
    // the wire stages reset high to match the pull-up idle level
    always @(posedge clk_sys) begin // RULE_01
        if (reset) begin
            rst_pin_s1_q <= 1'b0;
            rst_pin_s2_q <= 1'b0;
            sel_s1_q <= 2'h0;
            sel_s2_q <= 2'h0;
            irq_s1_q <= 1'b1;
            irq_s2_q <= 1'b1;
        end else begin
            rst_pin_s1_q <= reset_n_pin;
            rst_pin_s2_q <= rst_pin_s1_q;
            sel_s1_q <= ref_sel_pin;
            sel_s2_q <= sel_s1_q;
            irq_s1_q <= irq_pin_in;
            irq_s2_q <= irq_s1_q;
        end
    end

    // mode sequencing: standby, init, then hub operation
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_STANDBY: begin
                if (rst_pin_s2_q) begin
                    state_d = ST_INIT; // RULE_12
                end
            end
            ST_INIT: begin
                if (!rst_pin_s2_q) begin
                    state_d = ST_STANDBY;
                end else if (init_cnt_q >= INIT_CYCLES - 1) begin
                    state_d = ST_RUN;
                end
            end
            ST_RUN: begin
                if (!rst_pin_s2_q) begin
                    state_d = ST_STANDBY; // RULE_11
                end
            end
            default: begin
                state_d = ST_STANDBY;
            end
        endcase
    end

    always @(posedge clk_sys) begin
        if (reset) begin
            state_q <= ST_STANDBY;
            init_cnt_q <= 32'h0;
        end else begin
            state_q <= state_d;
            if (state_q == ST_INIT) begin
                init_cnt_q <= init_cnt_q + 32'h1;
            end else begin
                init_cnt_q <= 32'h0;
            end
        end
    end

    assign in_hub = (state_q != ST_STANDBY);
    assign hub_mode = (state_q == ST_RUN);
    assign init_busy = (state_q == ST_INIT);
    // standby stops the pll and powers the core down
    assign pll_enable = in_hub; // RULE_13
    assign core_power_en = in_hub; // RULE_13
    assign ref_freq_code = freq_q;

    // capture select pins and the pin level at the last init cycle;
    // the host must still be driving the pin low then to pick the second set;
    // the code is kept through standby on purpose: the pins are sampled
    // again at every init, so nothing stale survives into hub mode
    always @(posedge clk_sys) begin
        if (reset) begin
            freq_q <= `HMR_FREQ_38M4;
        end else if (state_q == ST_INIT && state_d == ST_RUN) begin // RULE_15
            freq_q <= {~irq_s2_q, sel_s2_q}; // RULE_02 RULE_03 RULE_04
        end
    end

    // software clears by writing ones to the status register
    assign clear_bits = (reg_wr && hub_mode && hit(reg_addr, `HMR_OFS_EVENT_STATUS)) ?
        reg_wdata : 8'h00;
    // conditions only count once the hub is running
    assign cond_live = hub_mode;
    // pad or trim the condition lines to the eight status bits; a narrower
    // hub ties the spare bits low, a wider one loses the lines above bit 7
    assign cond_wide = {8'h00, hub_cond};
    assign cond_bus = cond_wide[7:0];

    hmr_event_latch #(
        .WIDTH(8)
    ) u_latch (
        .clk_sys(clk_sys),
        .reset(reset | ~in_hub),
        .cond(cond_live ? cond_bus : 8'h00),
        .clear(clear_bits),
        .status(status)
    ); // RULE_07

    // mask register, wiped with the rest of the configuration in standby
    always @(posedge clk_sys) begin
        if (reset || !in_hub) begin
            mask_q <= `HMR_RST_ENABLE_MASK; // RULE_14 RULE_16
        end else if (reg_wr && hub_mode && hit(reg_addr, `HMR_OFS_ENABLE_MASK)) begin
            mask_q <= reg_wdata; // RULE_08
        end
    end

    // read data; unmapped addresses read zero
    always @* begin
        rdata_d = 8'h00;
        if (hit(reg_addr, `HMR_OFS_EVENT_STATUS)) begin
            rdata_d = status;
        end else if (hit(reg_addr, `HMR_OFS_ENABLE_MASK)) begin
            rdata_d = mask_q;
        end
    end

    // reads refused outside hub mode leave the last data standing
    always @(posedge clk_sys) begin
        if (reset) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd && hub_mode) begin
            reg_rdata <= rdata_d;
        end
    end

    // pin level source: suspend indicator or masked status
    always @(posedge clk_sys) begin
        if (reset || !hub_mode) begin
            irq_active_q <= 1'b0;
        end else if (suspend_level_indicate) begin
            irq_active_q <= hub_suspended; // RULE_10
        end else begin
            irq_active_q <= |(status & mask_q); // RULE_17
        end
    end

    // open drain: drive low only when active, otherwise release
    assign irq_pin_out = 1'b0; // RULE_09
    assign irq_pin_oe_n = ~irq_active_q; // RULE_09
endmodule

// ===== logic/hmr_defs.vh
// constants for the hub mode, reference clock select and interrupt block
// assumes inclusion by bare name from design files under logic/
`ifndef HMR_DEFS_VH
`define HMR_DEFS_VH

// register offsets and reset values on the serial slave port
`define HMR_OFS_EVENT_STATUS 8'he8
`define HMR_OFS_ENABLE_MASK 8'he9
`define HMR_RST_EVENT_STATUS 8'h00
`define HMR_RST_ENABLE_MASK 8'h00

// frequency codes, {secondary set, select[1:0]}
`define HMR_FREQ_38M4 3'h0
`define HMR_FREQ_26M0 3'h1
`define HMR_FREQ_19M2 3'h2
`define HMR_FREQ_12M0 3'h3
`define HMR_FREQ_24M0 3'h4
`define HMR_FREQ_27M0 3'h5
`define HMR_FREQ_25M0 3'h6
`define HMR_FREQ_50M0 3'h7

// initialisation stage length in ms, and cycles at the 100 MHz clock
`define HMR_INIT_TIME_MS 3
`define HMR_CLK_MHZ 100
`define HMR_INIT_CYCLES (`HMR_INIT_TIME_MS * 1000 * `HMR_CLK_MHZ)

`endif

// ===== logic/hmr_event_latch.v
// one sticky, event-driven status bit per condition line
// assumes conditions are already synchronous to clk_sys
`timescale 1ns/10ps
module hmr_event_latch #(
    parameter WIDTH = 8
) (
    input wire clk_sys,
    input wire reset,
    input wire [WIDTH-1:0] cond,
    input wire [WIDTH-1:0] clear,
    output wire [WIDTH-1:0] status
);
    reg [WIDTH-1:0] cond_q;
    reg [WIDTH-1:0] status_q;
    wire [WIDTH-1:0] rise;

    // only a fresh rising condition is an event; a held one is not
    assign rise = cond & ~cond_q; // RULE_06
    assign status = status_q;

    // set wins over a clear in the same cycle
    always @(posedge clk_sys) begin
        if (reset) begin
            cond_q <= {WIDTH{1'b0}};
            status_q <= {WIDTH{1'b0}}; // RULE_16
        end else begin
            cond_q <= cond;
            status_q <= (status_q & ~clear) | rise; // RULE_05
        end
    end
endmodule

// ===== testbench/hmr_host_model.sv
// host side of the shared interrupt wire, with its pull-up
// assumes the device only ever pulls the wire low through irq_pin_oe_n
`timescale 1ns/10ps
module hmr_host_model (
    input wire irq_pin_oe_n,
    input wire hold_low,
    output wire irq_pin_in
);
    // wire level: low if either party pulls, else the pull-up wins
    assign irq_pin_in = irq_pin_oe_n & ~hold_low;
endmodule

// ===== testbench/hmr_hub_chk.sv
// checker for the mode, select and interrupt pins of the hub control block
// assumes binding onto hmr_hub_ctrl, single clock clk_sys
`timescale 1ns/10ps
module hmr_hub_chk (
    input wire clk_sys,
    input wire reset,
    input wire reset_n_pin,
    input wire irq_pin_out,
    input wire irq_pin_oe_n,
    input wire hub_suspended,
    input wire suspend_level_indicate,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire [7:0] reg_rdata,
    input wire hub_mode,
    input wire init_busy,
    input wire pll_enable,
    input wire core_power_en,
    input wire [2:0] ref_freq_code
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    // open drain: data bit is never high, only the enable moves
    a_od_data_low: assert property (irq_pin_out == 1'b0)
        else $error("interrupt data bit driven high");
    // five cycles covers the pin synchroniser and the state register
    a_standby_quiet: assert property (!reset_n_pin [*5] |->
        !hub_mode && !pll_enable && !core_power_en) else $error("active in standby");
    a_hub_powered: assert property (hub_mode |-> pll_enable && core_power_en)
        else $error("hub mode without power");
    a_pin_released: assert property (!hub_mode && !$past(hub_mode) |-> irq_pin_oe_n)
        else $error("pin pulled outside hub mode");
    a_freq_held: assert property (hub_mode && $past(hub_mode) |-> $stable(ref_freq_code))
        else $error("frequency code moved");
    a_init_excl: assert property (init_busy |-> !hub_mode) else $error("init and hub");
    a_mask_back: assert property (hub_mode && reg_wr && reg_addr == 8'he9 ##1
        hub_mode && reg_rd && reg_addr == 8'he9 |=> reg_rdata == $past(reg_wdata, 2))
        else $error("mask readback wrong");
    a_susp_level: assert property (hub_mode && suspend_level_indicate ##1 hub_mode
        |-> irq_pin_oe_n == !$past(hub_suspended)) else $error("suspend level wrong");
    c_irq: cover property (hub_mode ##1 !irq_pin_oe_n);
    c_susp: cover property (hub_mode && suspend_level_indicate && hub_suspended);
    c_clear: cover property (hub_mode && reg_wr && reg_addr == 8'he8);
endmodule
bind hmr_hub_ctrl hmr_hub_chk chk_u (.clk_sys, .reset, .reset_n_pin, .irq_pin_out,
    .irq_pin_oe_n, .hub_suspended, .suspend_level_indicate, .reg_wr, .reg_rd, .reg_addr,
    .reg_wdata, .reg_rdata, .hub_mode, .init_busy, .pll_enable, .core_power_en,
    .ref_freq_code);

// ===== testbench/hmr_tb.sv
// self-checking bench for the hub control block
// assumes a short init count; inputs move on the falling edge
`timescale 1ns/10ps
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin mismatches++; \
    $display("wrong value %s exp %h got %h", n, e, s); end end
module tb;
    logic clk_sys = 0, reset = 1, reset_n_pin = 0, hold = 0, susp = 0, sli = 0;
    logic reg_wr = 0, reg_rd = 0;
    logic [1:0] sel = 0;
    logic [7:0] cond = 0, addr = 0, wdata = 0, rdata;
    wire pin_in, pin_out, oe_n, hub_mode, busy, pll, pwr;
    wire [2:0] code;
    int mismatches = 0, n_compared = 0, cyc = 0;
    hmr_hub_ctrl #(.INIT_CYCLES(20)) dut_u (.clk_sys(clk_sys), .reset(reset),
        .reset_n_pin(reset_n_pin), .ref_sel_pin(sel), .irq_pin_in(pin_in),
        .irq_pin_out(pin_out), .irq_pin_oe_n(oe_n), .hub_cond(cond), .hub_suspended(susp),
        .suspend_level_indicate(sli), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(addr),
        .reg_wdata(wdata), .reg_rdata(rdata), .hub_mode(hub_mode), .init_busy(busy),
        .pll_enable(pll), .core_power_en(pwr), .ref_freq_code(code));
    hmr_host_model host_u (.irq_pin_oe_n(oe_n), .hold_low(hold), .irq_pin_in(pin_in));
    initial forever #5 clk_sys = ~clk_sys;
    // a hang is cut short well past the expected run length
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            mismatches++;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        addr = a;
        wdata = d;
        reg_wr = 1;
        wait_cyc(1);
        reg_wr = 0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        addr = a;
        reg_rd = 1;
        wait_cyc(1);
        reg_rd = 0;
        `CHK("read data", e, rdata)
        // idle cycle so a following read never re-raises the strobe at once
        wait_cyc(1);
    endtask
    // wait for hub mode after a pin or reset release; the bound stops a hang
    task automatic wait_hub();
        for (int i = 0; i < 60 && hub_mode !== 1'b1; i++) wait_cyc(1);
        `CHK("hub mode", 1'b1, hub_mode)
        `CHK("pll enable", 1'b1, pll)
        `CHK("core power", 1'b1, pwr)
    endtask
    // standby, then a fresh init with the wire held low for the second set
    task automatic boot(input logic [2:0] c);
        reset_n_pin = 0;
        wait_cyc(6);
        `CHK("pll enable", 1'b0, pll)
        `CHK("core power", 1'b0, pwr)
        sel = c[1:0];
        hold = c[2];
        reset_n_pin = 1;
        wait_cyc(3);
        `CHK("init busy", 1'b1, busy)
        wait_hub();
        hold = 0;
        `CHK("frequency code", c, code)
    endtask
    initial begin
        wait_cyc(6);
        reset = 0;
        for (int c = 0; c < 8; c++) boot(c[2:0]);
        wr(8'he9, 8'ha5);
        rd(8'he9, 8'ha5);
        boot(3'h6);
        rd(8'he9, 8'h00);
        wr(8'he9, 8'h5a);
        // mid-run reset with the mode pin high: registers default, pins re-sampled
        reset = 1;
        wait_cyc(3);
        `CHK("hub mode in reset", 1'b0, hub_mode)
        reset = 0;
        wait_hub();
        rd(8'he9, 8'h00);
        `CHK("frequency code", 3'h2, code)
        rd(8'h10, 8'h00);
        wr(8'he9, 8'h01);
        cond = 8'h03;
        wait_cyc(3);
        `CHK("pin enable", 1'b0, oe_n)
        `CHK("pin data", 1'b0, pin_out)
        cond = 8'h02;
        rd(8'he8, 8'h03);
        wr(8'he8, 8'h03);
        wait_cyc(2);
        rd(8'he8, 8'h00);
        `CHK("pin enable", 1'b1, oe_n)
        cond = 8'h01;
        wait_cyc(2);
        rd(8'he8, 8'h01);
        wr(8'he9, 8'h00);
        wait_cyc(2);
        `CHK("pin enable", 1'b1, oe_n)
        sli = 1;
        susp = 1;
        wait_cyc(2);
        `CHK("pin enable", 1'b0, oe_n)
        susp = 0;
        wait_cyc(2);
        `CHK("pin enable", 1'b1, oe_n)
        report_and_stop();
    end
endmodule
